// *** hdl/nfcw_defines.svh ***
`ifndef NFCW_DEFINES_SVH
`define NFCW_DEFINES_SVH

// Command codes and lengths
`define NFCW_CMD_PROTO       8'h02
`define NFCW_CMD_IDLE        8'h07
`define NFCW_CMD_REGISTER_READ_CMD       8'h08
`define NFCW_CMD_REGISTER_WRITE_CMD       8'h09
`define NFCW_IDLE_LEN        8'h0e
`define NFCW_RD_LEN          8'h03
`define NFCW_WR_LEN_IDX      8'h03
`define NFCW_WR_LEN_VAL      8'h04

// Register addresses and index
`define NFCW_ADDR_WAKEFLAG   8'h62
`define NFCW_ADDR_ANALOG_RD  8'h69
`define NFCW_ADDR_ANALOG_WR  8'h68
`define NFCW_ANALOG_IDX      8'h04

// Analog tuning field layout and values
`define NFCW_SENS_MSB        5
`define NFCW_SENS_LSB        4
`define NFCW_LMI_MSB         3
`define NFCW_LMI_LSB         0
`define NFCW_ANALOG_MASK     8'h3f
`define NFCW_ANALOG_RESET    8'h00
`define NFCW_ANALOG_DEFAULT  8'h27

// Result codes and wake sources
`define NFCW_RES_OK          8'h00
`define NFCW_RES_ERR         8'h82
`define NFCW_SRC_FIELD       8'h04
`define NFCW_SRC_PIN         8'h08
`define NFCW_SRC_FIELD_BIT   2
`define NFCW_SRC_PIN_BIT     3
`define NFCW_ENTER_HIBERNATE 16'h0400

// Frame buffer and timing
`define NFCW_RX_DEPTH        16
`define NFCW_WAKE_TIME_US    6000
`define NFCW_CLK_MHZ         40

`endif

// *** hdl/nfcw_pkg.sv ***
package nfcw_pkg;

    typedef logic [7:0] nfcw_byte_t;

    typedef enum logic [2:0] {
        ST_POWERUP   = 3'b000,
        ST_WAKING    = 3'b001,
        ST_READY     = 3'b010,
        ST_HIBERNATE = 3'b011,
        ST_SLEEP     = 3'b100
    } nfcw_state_e;

endpackage

// *** hdl/nfcw_spi_slave.sv ***
`timescale 1ns/1ps
`default_nettype none

module nfcw_spi_slave (
    input  wire logic            core_clk,    // System clock
    input  wire logic            rst_n,       // Async reset, active low
    input  wire logic            spi_sck,     // Serial clock pin
    input  wire logic            spi_mosi,    // Serial data in pin
    input  wire logic            spi_cs_n,    // Chip select pin, active low
    input  wire nfcw_pkg::nfcw_byte_t tx_byte, // Byte to shift out next
    output logic                 spi_miso,    // Serial data out
    output nfcw_pkg::nfcw_byte_t rx_byte,     // Last received byte
    output logic                 rx_valid,    // Pulse: rx_byte complete
    output logic                 frame_start, // Pulse: select asserted
    output logic                 frame_end    // Pulse: select released
);
    import nfcw_pkg::*;

    logic       sck_meta, sck_sync, sck_prev;
    logic       mosi_meta, mosi_sync;
    logic       cs_meta, cs_sync, cs_prev;
    logic [2:0] bit_cnt;
    nfcw_byte_t rx_sh;
    nfcw_byte_t tx_sh;
    logic       sck_rise, sck_fall;

    // Two-stage synchronisers for all pins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_meta  <= 1'b0;
            sck_sync  <= 1'b0;
            sck_prev  <= 1'b0;
            mosi_meta <= 1'b0;
            mosi_sync <= 1'b0;
            cs_meta   <= 1'b1;
            cs_sync   <= 1'b1;
            cs_prev   <= 1'b1;
        end else begin
            sck_meta  <= spi_sck;
            sck_sync  <= sck_meta;
            sck_prev  <= sck_sync;
            mosi_meta <= spi_mosi;
            mosi_sync <= mosi_meta;
            cs_meta   <= spi_cs_n;
            cs_sync   <= cs_meta;
            cs_prev   <= cs_sync;
        end
    end

    assign sck_rise = sck_sync & ~sck_prev & ~cs_sync;
    assign sck_fall = ~sck_sync & sck_prev & ~cs_sync;

    // Frame boundary pulses
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_start <= 1'b0;
            frame_end   <= 1'b0;
        end else begin
            frame_start <= cs_prev & ~cs_sync;
            frame_end   <= ~cs_prev & cs_sync;
        end
    end

    // Receive on rising edge, mode 0
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt  <= 3'h0;
            rx_sh    <= 8'h00;
            rx_byte  <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (cs_prev & ~cs_sync) begin
                bit_cnt <= 3'h0;
            end else if (sck_rise) begin
                rx_sh   <= {rx_sh[6:0], mosi_sync};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    rx_byte  <= {rx_sh[6:0], mosi_sync};
                    rx_valid <= 1'b1;
                end
            end
        end
    end

    // Transmit on falling edge, next byte loaded at byte boundary
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh    <= 8'h00;
            spi_miso <= 1'b0;
        end else if (cs_prev & ~cs_sync) begin
            spi_miso <= tx_byte[7];
            tx_sh    <= {tx_byte[6:0], 1'b0};
        end else if (sck_fall) begin
            if (bit_cnt == 3'h0) begin
                spi_miso <= tx_byte[7];
                tx_sh    <= {tx_byte[6:0], 1'b0};
            end else begin
                spi_miso <= tx_sh[7];
                tx_sh    <= {tx_sh[6:0], 1'b0};
            end
        end
    end

endmodule

`default_nettype wire

// *** hdl/nfcw_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "nfcw_defines.svh"

// Overview of operation
// - After power-on wait in power-up for wake
// - Wake pulse selects SPI, ready after 6 ms
// - Hibernate wakes only on wake pin pulse
// - Low power keeps only wake source resources
// - Read command 08 03 addr 01 00 returns data
// - Bad read/write length answers 82 00
// - Write command 09, length 3 or 4, increment
// - Tuning register lives at analog index 04
// - Bits 5:4 select demodulator sensitivity
// - Bits 3:0 set load modulation index
// - Protocol choice loads defaults, writes override
// - Tuning register cleared on power loss
// - Successful write answers 00 00
// - Idle is 07 0E, source, three control words
// - Leaving low power answers 00 01 source
module nfcw_core #(
    parameter int WAKE_CYCLES = `NFCW_WAKE_TIME_US * `NFCW_CLK_MHZ
) (
    input  wire logic            core_clk,         // System clock, 40 MHz
    input  wire logic            rst_n,            // Async reset, active low
    input  wire logic            spi_sck,          // Serial clock pin
    input  wire logic            spi_mosi,         // Serial data in pin
    input  wire logic            spi_cs_n,         // Chip select, active low
    input  wire logic            wake_n,           // Wake pin, low pulse wakes
    input  wire logic            field_detect,     // Field detector output
    output logic                 spi_miso,         // Serial data out
    output logic                 resp_ready,       // Reply waiting to be read
    output logic                 dev_ready,        // Ready state reached
    output logic                 spi_selected,     // Host interface chosen
    output logic                 field_det_en,     // Field detector powered
    output logic                 slow_osc_en,      // Slow oscillator powered
    output nfcw_pkg::nfcw_byte_t analog_rf_tuning  // Tuning to analog front end
);
    import nfcw_pkg::*;
    localparam int CW = $clog2(WAKE_CYCLES + 1);
    if (WAKE_CYCLES < 2) begin : g_bad_wake
        $error("WAKE_CYCLES must be at least 2");
    end

    nfcw_state_e   state_reg;
    logic [CW-1:0] wait_cnt_reg;
    nfcw_byte_t    rx_mem [0:`NFCW_RX_DEPTH-1];
    logic [4:0]    rx_cnt_reg;
    nfcw_byte_t    resp_mem [0:2];
    logic [1:0]    resp_len_reg, resp_idx_reg;
    nfcw_byte_t    wake_src_reg, wake_flag_reg, index_reg;
    logic          wake_meta, wake_sync, wake_prev, fld_meta, fld_sync;
    nfcw_byte_t    rx_byte, tx_byte, cmd, len, wake_code;
    logic          rx_valid, frame_start, frame_end, do_wake;
    logic          wake_fall, exec, cnt_ok, rd_ok, wr_ok, idle_ok, proto;

    nfcw_spi_slave u_spi (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .spi_sck     (spi_sck),
        .spi_mosi    (spi_mosi),
        .spi_cs_n    (spi_cs_n),
        .tx_byte     (tx_byte),
        .spi_miso    (spi_miso),
        .rx_byte     (rx_byte),
        .rx_valid    (rx_valid),
        .frame_start (frame_start),
        .frame_end   (frame_end)
    );

    // Synchronise wake pin and field detector
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_meta <= 1'b1;
            wake_sync <= 1'b1;
            wake_prev <= 1'b1;
            fld_meta  <= 1'b0;
            fld_sync  <= 1'b0;
        end else begin
            wake_meta <= wake_n;
            wake_sync <= wake_meta;
            wake_prev <= wake_sync;
            fld_meta  <= field_detect;
            fld_sync  <= fld_meta;
        end
    end

    // Command decode from the collected frame
    assign wake_fall = wake_prev & ~wake_sync;
    assign cmd       = rx_mem[0];
    assign len       = rx_mem[1];
    assign cnt_ok    = ({4'h0, rx_cnt_reg} == ({1'b0, len} + 9'h002));
    assign exec      = frame_end & (state_reg == ST_READY) & ~resp_ready;
    assign idle_ok   = (cmd == `NFCW_CMD_IDLE) & (len == `NFCW_IDLE_LEN) & cnt_ok;
    assign rd_ok     = (cmd == `NFCW_CMD_REGISTER_READ_CMD) & (len == `NFCW_RD_LEN) & cnt_ok
                     & ((rx_mem[2] == `NFCW_ADDR_WAKEFLAG)
                     | (rx_mem[2] == `NFCW_ADDR_ANALOG_RD));
    assign wr_ok     = (cmd == `NFCW_CMD_REGISTER_WRITE_CMD) & cnt_ok
                     & ((len == `NFCW_WR_LEN_IDX) | (len == `NFCW_WR_LEN_VAL))
                     & (rx_mem[2] == `NFCW_ADDR_ANALOG_WR);
    assign proto     = (cmd == `NFCW_CMD_PROTO);
    assign tx_byte   = (resp_ready && (resp_idx_reg < resp_len_reg))
                     ? resp_mem[resp_idx_reg] : 8'h00;

    // Wake event per state; hibernate listens to the pin only
    always_comb begin
        do_wake   = 1'b0;
        wake_code = `NFCW_SRC_PIN;
        if (state_reg == ST_HIBERNATE) begin
            do_wake = wake_fall;
        end else if (state_reg == ST_SLEEP) begin
            if (wake_fall && wake_src_reg[`NFCW_SRC_PIN_BIT]) begin
                do_wake = 1'b1;
            end else if (fld_sync && wake_src_reg[`NFCW_SRC_FIELD_BIT]) begin
                do_wake   = 1'b1;
                wake_code = `NFCW_SRC_FIELD;
            end
        end
    end

    // Frame collection, capped at buffer depth
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_reg <= 5'h00;
            for (int i = 0; i < `NFCW_RX_DEPTH; i++) begin
                rx_mem[i] <= 8'h00;
            end
        end else if (frame_start) begin
            rx_cnt_reg <= 5'h00;
        end else if (rx_valid) begin
            if (rx_cnt_reg < 5'(`NFCW_RX_DEPTH)) begin
                rx_mem[rx_cnt_reg[3:0]] <= rx_byte;
            end
            if (rx_cnt_reg != 5'h1f) begin
                rx_cnt_reg <= rx_cnt_reg + 5'h01;
            end
        end
    end
    // Power state machine; control words arrive first byte high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= ST_POWERUP;
            wait_cnt_reg  <= '0;
            spi_selected  <= 1'b0;
            dev_ready     <= 1'b0;
            field_det_en  <= 1'b0;
            slow_osc_en   <= 1'b0;
            wake_src_reg  <= 8'h00;
        end else begin
            case (state_reg)
                ST_POWERUP: begin
                    if (wake_fall) begin
                        state_reg    <= ST_WAKING;
                        wait_cnt_reg <= '0;
                        spi_selected <= 1'b1;
                    end
                end
                ST_WAKING: begin
                    if (wait_cnt_reg == CW'(WAKE_CYCLES - 1)) begin
                        state_reg <= ST_READY;
                        dev_ready <= 1'b1;
                    end else begin
                        wait_cnt_reg <= wait_cnt_reg + 1'b1;
                    end
                end
                ST_READY: begin
                    if (exec && idle_ok) begin
                        wake_src_reg <= rx_mem[2];
                        dev_ready    <= 1'b0;
                        if ({rx_mem[3], rx_mem[4]} == `NFCW_ENTER_HIBERNATE) begin
                            state_reg <= ST_HIBERNATE;
                        end else begin
                            state_reg    <= ST_SLEEP;
                            slow_osc_en  <= 1'b1;
                            field_det_en <= rx_mem[2][`NFCW_SRC_FIELD_BIT];
                        end
                    end
                end
                ST_HIBERNATE, ST_SLEEP: begin
                    if (do_wake) begin
                        state_reg    <= ST_READY;
                        dev_ready    <= 1'b1;
                        slow_osc_en  <= 1'b0;
                        field_det_en <= 1'b0;
                    end
                end
                default: state_reg <= ST_POWERUP;
            endcase
        end
    end
    // Wake-up flag register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_flag_reg <= 8'h00;
        end else if (do_wake) begin
            wake_flag_reg <= wake_code;
        end
    end

    // Analog tuning register and its index
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_rf_tuning <= `NFCW_ANALOG_RESET;
            index_reg        <= 8'h00;
        end else if (exec && proto) begin
            analog_rf_tuning <= `NFCW_ANALOG_DEFAULT;
        end else if (exec && wr_ok) begin
            if (len == `NFCW_WR_LEN_VAL) begin
                if (rx_mem[4] == `NFCW_ANALOG_IDX) begin
                    analog_rf_tuning <= rx_mem[5] & `NFCW_ANALOG_MASK;
                end
                index_reg <= rx_mem[4] + {7'h00, rx_mem[3][0]};
            end else begin
                index_reg <= rx_mem[4];
            end
        end
    end

    // Reply buffer: loaded by commands and wake-ups, drained by a read frame
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_ready   <= 1'b0;
            resp_len_reg <= 2'h0;
            resp_idx_reg <= 2'h0;
            for (int i = 0; i < 3; i++) begin
                resp_mem[i] <= 8'h00;
            end
        end else begin
            if (frame_end) begin
                resp_idx_reg <= 2'h0;
            end else if (rx_valid && resp_ready && resp_idx_reg != 2'h3) begin
                resp_idx_reg <= resp_idx_reg + 2'h1;
            end
            if (do_wake) begin
                resp_mem[0]  <= `NFCW_RES_OK;
                resp_mem[1]  <= 8'h01;
                resp_mem[2]  <= wake_code;
                resp_len_reg <= 2'h3;
                resp_ready   <= 1'b1;
            end else if (exec && !idle_ok) begin
                resp_ready   <= 1'b1;
                resp_len_reg <= 2'h2;
                resp_mem[0]  <= `NFCW_RES_OK;
                resp_mem[1]  <= 8'h00;
                if (rd_ok) begin
                    resp_mem[1]  <= 8'h01;
                    resp_mem[2]  <= (rx_mem[2] == `NFCW_ADDR_WAKEFLAG) ? wake_flag_reg
                                  : (index_reg == `NFCW_ANALOG_IDX) ? analog_rf_tuning : 8'h00;
                    resp_len_reg <= 2'h3;
                end else if (!(wr_ok || proto)) begin
                    resp_mem[0] <= `NFCW_RES_ERR;
                end
            end else if (frame_end && resp_ready) begin
                resp_ready <= 1'b0;
            end
        end
    end
    chk_powerup_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_POWERUP) && !wake_fall |=> (state_reg == ST_POWERUP) && !resp_ready)
        else $error("left power-up without wake pulse");
    chk_ready_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_WAKING) && (wait_cnt_reg == CW'(WAKE_CYCLES - 1))
        |=> (state_reg == ST_READY) && dev_ready && spi_selected)
        else $error("ready not reached at end of wake delay");
    chk_hibernate_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_HIBERNATE) && !wake_fall |=> (state_reg == ST_HIBERNATE))
        else $error("hibernate left without pin pulse");
    chk_power_gating: assert property (@(posedge core_clk) disable iff (!rst_n)
        field_det_en |-> (state_reg == ST_SLEEP) && wake_src_reg[`NFCW_SRC_FIELD_BIT])
        else $error("field detector powered outside field-wake sleep");
    chk_length_error: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && ((cmd == `NFCW_CMD_REGISTER_WRITE_CMD) || (cmd == `NFCW_CMD_REGISTER_READ_CMD)) && !rd_ok && !wr_ok
        |=> resp_ready && (resp_mem[0] == `NFCW_RES_ERR) && (resp_mem[1] == 8'h00))
        else $error("bad length not answered with error");
    chk_write_reply: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && wr_ok |=> (resp_mem[0] == `NFCW_RES_OK) && (resp_mem[1] == 8'h00)
        && (resp_len_reg == 2'h2))
        else $error("write reply wrong");
    chk_tuning_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && wr_ok && (len == `NFCW_WR_LEN_VAL) && (rx_mem[4] == `NFCW_ANALOG_IDX)
        |=> analog_rf_tuning == ($past(rx_mem[5]) & `NFCW_ANALOG_MASK))
        else $error("tuning register not updated");
    chk_proto_default: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && proto |=> analog_rf_tuning == `NFCW_ANALOG_DEFAULT)
        else $error("protocol choice did not load default");
    chk_wake_reply: assert property (@(posedge core_clk) disable iff (!rst_n)
        do_wake |=> resp_ready && (resp_mem[1] == 8'h01) && (resp_mem[2] == $past(wake_code))
        && (state_reg == ST_READY))
        else $error("wake reply wrong");
    chk_no_early_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
        frame_end && (state_reg != ST_READY) |=> $stable(analog_rf_tuning) && $stable(index_reg))
        else $error("command taken before ready");
endmodule

`default_nettype wire

// *** bench/nfcw_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module nfcw_host_model (
    output logic      spi_sck,  // Link clock, idles low
    output logic      spi_mosi, // Data to device
    output logic      spi_cs_n, // Frame select, active low
    input  wire logic spi_miso  // Data from device
);
    // Link idle: clock low, frame closed
    initial begin
        spi_sck = 1'b0;
        spi_mosi = 1'b0;
        spi_cs_n = 1'b1;
    end

    // One frame of n bytes, MSB first, first three bytes back in rx
    task automatic xfer(input logic [127:0] v, input int n, output logic [23:0] rx);
        rx = '0;
        spi_cs_n = 1'b0;
        #200;
        for (int i = 8 * n - 1; i >= 0; i--) begin
            spi_mosi = v[i];
            #100 spi_sck = 1'b1;
            if (i >= 8 * n - 24) begin
                rx = {rx[22:0], spi_miso};
            end
            #100 spi_sck = 1'b0;
        end
        #100 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi; // Released line shows no stale bit
        #200;
    endtask
endmodule

`default_nettype wire

// *** bench/idle_wake_and_analog_reg_cmds_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end

module idle_wake_and_analog_reg_cmds_tb;
    import nfcw_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       wake_n = 1'b1;
    logic       field_detect = 1'b0;
    logic       spi_sck, spi_mosi, spi_cs_n, spi_miso;
    logic       resp_ready, dev_ready, spi_selected, field_det_en, slow_osc_en;
    nfcw_byte_t analog_rf_tuning;
    logic [23:0] rx;
    int         error_cnt = 0;
    int         num_checks = 0;

    // Short wake count keeps the run brief
    nfcw_core #(.WAKE_CYCLES(20)) nfcw_core_i (.core_clk, .rst_n, .spi_sck, .spi_mosi,
        .spi_cs_n, .wake_n, .field_detect, .spi_miso, .resp_ready, .dev_ready,
        .spi_selected, .field_det_en, .slow_osc_en, .analog_rf_tuning);
    nfcw_host_model nfcw_host_model_i (.spi_sck, .spi_mosi, .spi_cs_n, .spi_miso);

    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;

    // Wait for a reply, then read it in a separate frame
    task automatic rd();
        int k;
        k = 0;
        while (resp_ready !== 1'b1 && k < 50) begin
            @(negedge core_clk);
            k++;
        end
        `CHK(resp_ready, 1'b1)
        nfcw_host_model_i.xfer(128'h0, 3, rx);
    endtask

    // Command frame and its reply
    task automatic cmd(input logic [127:0] v, input int n, input logic [23:0] exp);
        nfcw_host_model_i.xfer(v, n, rx);
        rd();
        `CHK(rx, exp)
    endtask

    // Frame that must be ignored
    task automatic lost(input logic [127:0] v, input int n);
        nfcw_host_model_i.xfer(v, n, rx);
        repeat (20) @(negedge core_clk);
        `CHK(resp_ready, 1'b0)
    endtask

    // Low pulse on the wake pin, then wait for ready
    task automatic wake();
        int k;
        @(negedge core_clk);
        wake_n = 1'b0;
        repeat (4) @(negedge core_clk);
        wake_n = 1'b1;
        k = 0;
        while (dev_ready !== 1'b1 && k < 60) begin
            @(negedge core_clk);
            k++;
        end
        `CHK(dev_ready, 1'b1)
    endtask

    // Power-up holds until a wake pulse
    task automatic t_powerup();
        `CHK(analog_rf_tuning, 8'h00)
        `CHK(dev_ready, 1'b0)
        lost(40'h0903680004, 5);
        wake();
        `CHK(spi_selected, 1'b1)
        `CHK(resp_ready, 1'b0)
        $display("powerup test done");
    endtask

    // Register commands and tuning fields
    task automatic t_regs();
        logic [7:0] vals[5] = '{8'h01, 8'h07, 8'h0f, 8'h20, 8'h2f};
        cmd(32'h02021208, 4, 24'h000000);
        `CHK(analog_rf_tuning, 8'h27)
        cmd(40'h0903680004, 5, 24'h000000);
        cmd(40'h0803690100, 5, 24'h000127);
        cmd(48'h090468010425, 6, 24'h000000);
        `CHK(analog_rf_tuning, 8'h25)
        cmd(40'h0803690100, 5, 24'h000100);
        cmd(40'h0903680004, 5, 24'h000000);
        cmd(40'h0803690100, 5, 24'h000125);
        foreach (vals[i]) begin
            cmd({40'h0904680004, vals[i]}, 6, 24'h000000);
            `CHK(analog_rf_tuning, vals[i])
        end
        cmd(48'h080469010000, 6, 24'h820000);
        cmd(56'h09056800042500, 7, 24'h820000);
        $display("register test done");
    endtask

    // Sleep with pin and field wake, then hibernate
    task automatic t_low_power();
        nfcw_host_model_i.xfer(128'h070e0801003800180000600000000000, 16, rx);
        repeat (10) @(negedge core_clk);
        `CHK(dev_ready, 1'b0)
        `CHK(slow_osc_en, 1'b1)
        `CHK(field_det_en, 1'b0)
        lost(48'h09046800043f, 6);
        `CHK(analog_rf_tuning, 8'h2f)
        wake();
        `CHK(slow_osc_en, 1'b0)
        rd();
        `CHK(rx, 24'h000108)
        cmd(40'h0803620100, 5, 24'h000108);
        nfcw_host_model_i.xfer(128'h070e0401423800180000600000000000, 16, rx);
        repeat (10) @(negedge core_clk);
        `CHK(field_det_en, 1'b1)
        field_detect = 1'b1;
        rd();
        `CHK(rx, 24'h000104)
        field_detect = 1'b0;
        cmd(40'h0803620100, 5, 24'h000104);
        nfcw_host_model_i.xfer(128'h070e0804000400180000000000000000, 16, rx);
        field_detect = 1'b1;
        repeat (30) @(negedge core_clk);
        `CHK(dev_ready, 1'b0)
        `CHK(field_det_en, 1'b0)
        `CHK(slow_osc_en, 1'b0)
        field_detect = 1'b0;
        wake();
        rd();
        `CHK(rx[23:8], 16'h0001)
        $display("low power test done");
    endtask

    // Power loss clears tuning and returns to power-up
    task automatic t_power_cycle();
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK(analog_rf_tuning, 8'h00)
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        `CHK(dev_ready, 1'b0)
        lost(32'h02021208, 4);
        $display("power cycle test done");
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        t_powerup();
        t_regs();
        t_low_power();
        t_power_cycle();
        end_sim();
    end

    // Watchdog
    initial begin
        repeat (80000) @(posedge core_clk);
        error_cnt++;
        $display("Error %0t: run timed out", $time);
        end_sim();
    end
endmodule

`default_nettype wire
